// File: verilog/interrupt_entry_return_sequencer.sv
// Purpose: Prioritised interrupt acceptance, context save, vector fetch and return sequencing.
// Assumes: One clock edge is one instruction cycle; the core drives the op strobes.
// Notes:   Flags are set by sources and edges, cleared by software and on acceptance; set wins.
// Behaviour
// - Sample flags every cycle, then compare priorities.
// - Flag interrupts only when its enable set.
// - Current instruction always completes before service.
// - Present only priority strictly above CPU field.
// - Push PC, status low, upper bit, frame bit.
// - Load accepted priority into CPU priority field.
// - Return pops context, restoring prior priority.
// - Nesting enabled at reset; higher preempts.
// - Nesting disabled forces field to seven.
// - Field read-only while nesting disabled.
// - Pending enabled source wakes sleeping core.
// - After wake, vector if above level, else resume.
// - Priority zero source disabled, cannot wake.
// - Pin zero edge also requests conversion.
// - Five pins, per-pin edge polarity select.
// - Entry takes ten cycles, first completes instruction.
// - Cycle two buffers context; three fetches vector.
// - Same latency for one and two-cycle instructions.
// - Return pops two cycles, fetch, resumes fourth.
// - Latency bit zero fixed, needs top master.
// - Fixed mode adds cycle for listed accesses; code adds it whenever the latency bit is zero, whatever the master.
// - Exception time 13 fixed, 9-13 variable.
// - Upper bit above field forms four-bit level.
// - Source bits ordered by vector number.
`timescale 1ns/1ps
module interrupt_entry_return_sequencer #(
  parameter int unsigned NSRC = irq_seq_pkg::NUM_SOURCES,
  parameter int unsigned NPIN = irq_seq_pkg::NUM_EXT_PINS
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Request pulses in vector order; pins on low bits.
  input  wire logic [NSRC-1:0]   srcRequest,
  // Flag clears.
  input  wire logic [NSRC-1:0]   flagClear,
  // Enables.
  input  wire logic [NSRC-1:0]   irqEnableRegs,
  // Priorities, three bits each.
  input  wire logic [NSRC*3-1:0] srcPriority,
  // Pins and polarity (1 = falling).
  input  wire logic [NPIN-1:0]   extPin,
  input  wire logic [NPIN-1:0]   extEdgePolarity,
  // Mode controls.
  input  wire logic              nestingDisable,
  input  wire logic              latencyMode,
  input  wire logic [2:0]        busMasterPriority,
  // Field write.
  input  wire logic              prioWrite,
  input  wire logic [2:0]        prioWriteData,
  // Core strobes.
  input  wire logic              instrDone,
  input  wire logic              returnFromIrqOp,
  input  wire logic              powerSaveOp,
  // Extra-cycle causes.
  input  wire logic              doubleMoveVis,
  input  wire logic              visStall,
  input  wire logic              visRepeatLast,
  // Live context.
  input  wire logic [23:0]       currentPc,
  input  wire logic [7:0]        statusLowByte,
  input  wire logic              stackFrameActive,
  // Popped context.
  input  wire logic [23:0]       popPc,
  input  wire logic [7:0]        popStatusLow,
  input  wire logic              popUpperBit,
  input  wire logic              popFrameActive,
  output logic [NSRC-1:0]        irqFlagRegs,
  output logic [2:0]             cpuPriorityField,
  output logic                   priorityUpperBit,
  output logic [3:0]             cpuLevel,
  output logic                   irqPresent,
  output logic                   wakeUp,
  output logic                   sleeping,
  output logic                   entryActive,
  output logic                   returnActive,
  output logic [3:0]             entryCycle,
  output logic                   pushValid,
  output logic [23:0]            pushPc,
  output logic [7:0]             pushStatusLow,
  output logic                   pushUpperBit,
  output logic                   pushFrameActive,
  output logic                   vectorFetch,
  output logic [3:0]             vectorIdx,
  output logic                   isrStart,
  output logic                   resumeExec,
  output logic [23:0]            restorePc,
  output logic [7:0]             restoreStatusLow,
  output logic                   restoreFrameActive,
  output logic                   convRequest,
  output logic                   fixedLatency,
  output logic [3:0]             excTime
);

  // All sequencer state.
  typedef struct packed {
    irq_seq_pkg::seq_state_t state;
    logic [NSRC-1:0] flags;
    logic [2:0]      prio;
    logic            upper;
    logic [3:0]      cyc;
    logic [3:0]      entryLen;
    logic [3:0]      idx;
    logic [2:0]      acceptPrio;
    logic [23:0]     tmpPc;
    logic [7:0]      tmpSrl;
    logic            pushV;
    logic [23:0]     pushPcR;
    logic [7:0]      pushSrlR;
    logic            pushUp;
    logic            pushSfa;
    logic            vecF;
    logic            isrS;
    logic            resume;
    logic [23:0]     rPc;
    logic [7:0]      rSrl;
    logic            rSfa;
    logic            conv;
    logic            wake;
    logic [3:0]      excT;
  } seq_t;

  seq_t stateReg;   // Registered state.
  seq_t stateNext;  // Next state.

  logic [NPIN-1:0] pinEdge;   // Edge pulses from the external pins.
  logic [NSRC-1:0] pending;   // Flag and enable.
  logic            anyValid;  // Some enabled nonzero-priority source pending.
  logic [3:0]      winIdx;    // Winning source.
  logic [2:0]      winPrio;   // Winning priority.
  logic [NSRC-1:0] extSet;    // Pin edges aligned onto source bits.
  logic            extra;     // One extra entry cycle needed while the latency bit is zero.

  // Pin edges; pin zero also feeds the converter.
  ext_edge_detect #(.PINS(NPIN)) u_edges (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .pinIn        (extPin),
    .edgePolarity (extEdgePolarity),
    .edgeSeen     (pinEdge)
  );

  // Index 0 has the top natural order.
  prio_arbiter #(.N(NSRC)) u_arb (
    .pending    (pending),
    .priorities (srcPriority),
    .anyValid   (anyValid),
    .winIdx     (winIdx),
    .winPrio    (winPrio)
  );

  // Place pin edges on the lowest source bits.
  always_comb begin
    extSet = '0;
    extSet[NPIN-1:0] = pinEdge;
  end

  assign pending = stateReg.flags & irqEnableRegs;
  assign extra   = doubleMoveVis | visStall | visRepeatLast;

  // Sequencer next-state logic.
  always_comb begin
    stateNext        = stateReg;
    stateNext.pushV  = 1'b0;
    stateNext.vecF   = 1'b0;
    stateNext.isrS   = 1'b0;
    stateNext.resume = 1'b0;
    stateNext.conv   = pinEdge[0];
    // Flags sampled every cycle; set beats clear.
    stateNext.flags = (stateReg.flags & ~flagClear) | srcRequest | extSet;
    stateNext.wake  = anyValid;
    // Exception time follows the latency mode every cycle.
    stateNext.excT  = fixedLatency ? irq_seq_pkg::EXC_FIXED : irq_seq_pkg::EXC_VAR_MIN;
    // Software may write the field only while nesting is enabled.
    if (prioWrite && !nestingDisable && stateReg.state == irq_seq_pkg::ST_RUN) begin
      stateNext.prio = prioWriteData;
    end
    case (stateReg.state)
      irq_seq_pkg::ST_RUN: begin
        // Strict compare; the upper bit masks all users.
        if (anyValid && !stateReg.upper && winPrio > stateReg.prio && instrDone) begin
          stateNext.state      = irq_seq_pkg::ST_ENTRY;
          stateNext.cyc        = 4'h1;
          stateNext.idx        = winIdx;
          stateNext.acceptPrio = winPrio;
          // Same length for any instruction; extras whenever the latency bit is zero.
          stateNext.entryLen   = (!latencyMode && extra) ? irq_seq_pkg::ENTRY_CYCLES + 4'h1
                                                         : irq_seq_pkg::ENTRY_CYCLES;
          stateNext.flags[winIdx] = srcRequest[winIdx] | extSet[winIdx];
        end else if (returnFromIrqOp) begin
          stateNext.state = irq_seq_pkg::ST_RETURN;
          stateNext.cyc   = 4'h1;
        end else if (powerSaveOp) begin
          stateNext.state = irq_seq_pkg::ST_SLEEP;
        end
      end
      irq_seq_pkg::ST_ENTRY: begin
        stateNext.cyc = stateReg.cyc + 4'h1;
        if (stateReg.cyc == 4'h1) begin
          // Context copied to the buffer while a no-op runs.
          stateNext.tmpPc  = currentPc;
          stateNext.tmpSrl = statusLowByte;
        end
        if (stateReg.cyc == 4'h2) begin
          stateNext.vecF     = 1'b1;
          stateNext.pushV    = 1'b1;
          stateNext.pushPcR  = stateReg.tmpPc;
          stateNext.pushSrlR = stateReg.tmpSrl;
          stateNext.pushUp   = stateReg.upper;
          stateNext.pushSfa  = stackFrameActive;
          stateNext.prio     = nestingDisable ? irq_seq_pkg::PRIO_NEST_OFF : stateReg.acceptPrio;
        end
        if (stateReg.cyc == stateReg.entryLen - 4'h1) begin
          stateNext.isrS  = 1'b1;
          stateNext.state = irq_seq_pkg::ST_RUN;
          stateNext.cyc   = 4'h0;
        end
      end
      irq_seq_pkg::ST_RETURN: begin
        stateNext.cyc = stateReg.cyc + 4'h1;
        if (stateReg.cyc == 4'h2) begin
          // Popped context restores the level held before entry.
          stateNext.rPc   = popPc;
          stateNext.rSrl  = popStatusLow;
          stateNext.rSfa  = popFrameActive;
          stateNext.upper = popUpperBit;
          stateNext.prio  = popStatusLow[7:5];
        end
        if (stateReg.cyc == irq_seq_pkg::RETURN_CYCLES) begin
          stateNext.resume = 1'b1;
          stateNext.state  = irq_seq_pkg::ST_RUN;
          stateNext.cyc    = 4'h0;
        end
      end
      irq_seq_pkg::ST_SLEEP: begin
        // Wake to run, which vectors or continues.
        if (anyValid) begin
          stateNext.state  = irq_seq_pkg::ST_RUN;
          stateNext.resume = !(winPrio > stateReg.prio) || stateReg.upper;
        end
      end
      default: begin
        stateNext.state = irq_seq_pkg::ST_RUN;
      end
    endcase
  end

  // Synchronous reset to the idle state.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign irqFlagRegs = stateReg.flags;
  assign cpuPriorityField = stateReg.prio;
  assign priorityUpperBit = stateReg.upper;
  assign cpuLevel = {stateReg.upper, stateReg.prio};
  assign irqPresent = anyValid && !stateReg.upper && winPrio > stateReg.prio;
  assign wakeUp = stateReg.wake;
  assign sleeping = stateReg.state == irq_seq_pkg::ST_SLEEP;
  assign entryActive = stateReg.state == irq_seq_pkg::ST_ENTRY;
  assign returnActive = stateReg.state == irq_seq_pkg::ST_RETURN;
  assign entryCycle = stateReg.cyc;
  assign pushValid = stateReg.pushV;
  assign pushPc = stateReg.pushPcR;
  assign pushStatusLow = stateReg.pushSrlR;
  assign pushUpperBit = stateReg.pushUp;
  assign pushFrameActive = stateReg.pushSfa;
  assign vectorFetch = stateReg.vecF;
  assign vectorIdx = stateReg.idx;
  assign isrStart = stateReg.isrS;
  assign resumeExec = stateReg.resume;
  assign restorePc = stateReg.rPc;
  assign restoreStatusLow = stateReg.rSrl;
  assign restoreFrameActive = stateReg.rSfa;
  assign convRequest = stateReg.conv;
  assign fixedLatency = !latencyMode && busMasterPriority == irq_seq_pkg::MASTER_TOP;
  assign excTime = stateReg.excT;

endmodule : interrupt_entry_return_sequencer

// File: verilog/irq_seq_pkg.sv
// Purpose: Shared constants and types for the interrupt entry and return sequencer.
// Assumes: One clock edge per instruction cycle.
// Notes:   Widths and timing counts used by more than one file live here.
package irq_seq_pkg;

  // Peripheral source count.
  localparam int unsigned NUM_SOURCES    = 16;
  // Number of external interrupt pins.
  localparam int unsigned NUM_EXT_PINS   = 5;
  // Priority width.
  localparam int unsigned PRIO_W         = 3;
  // Width of a source index.
  localparam int unsigned IDX_W          = 4;
  // Program counter width.
  localparam int unsigned PC_W           = 24;
  // Status low byte width.
  localparam int unsigned SRL_W          = 8;
  // Field value while nesting is disabled.
  localparam logic [2:0]  PRIO_NEST_OFF  = 3'h7;
  // Disabled priority level.
  localparam logic [2:0]  PRIO_DISABLED  = 3'h0;
  // Bus master priority for CPU top precedence.
  localparam logic [2:0]  MASTER_TOP     = 3'h0;
  // Entry sequence length in instruction cycles.
  localparam logic [3:0]  ENTRY_CYCLES   = 4'ha;
  // Return cycles before resume.
  localparam logic [3:0]  RETURN_CYCLES  = 4'h3;
  // Exception time, fixed mode.
  localparam logic [3:0]  EXC_FIXED      = 4'hd;
  // Exception time, variable mode minimum.
  localparam logic [3:0]  EXC_VAR_MIN    = 4'h9;
  // Latency-mode reset value: fixed.
  localparam logic        LAT_MODE_RESET = 1'b0;
  // Nesting-disable reset value: enabled.
  localparam logic        NEST_DIS_RESET = 1'b0;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_ENTRY  = 2'b01,
    ST_RETURN = 2'b10,
    ST_SLEEP  = 2'b11
  } seq_state_t;

endpackage : irq_seq_pkg

// File: verilog/ext_edge_detect.sv
// Purpose: Edge detector for the external interrupt pins.
// Assumes: Pins are asynchronous to the clock.
// Notes:   Three flip-flops; a change counts once the second and third agree.
`timescale 1ns/1ps
module ext_edge_detect #(
  parameter int unsigned PINS = 5
) (
  input  wire logic            clock,
  input  wire logic            sys_rst,
  input  wire logic [PINS-1:0] pinIn,
  input  wire logic [PINS-1:0] edgePolarity,
  output logic      [PINS-1:0] edgeSeen
);

  // All state of the detector in one record.
  typedef struct packed {
    logic [PINS-1:0] sync1;
    logic [PINS-1:0] sync2;
    logic [PINS-1:0] sync3;
    logic [PINS-1:0] stable;
    logic [PINS-1:0] edgeOut;
  } edge_state_t;

  edge_state_t stateReg;   // Registered state.
  edge_state_t stateNext;  // Next state.

  // Stable level moves when stages two and three agree.
  // Polarity high selects falling edges.
  always_comb begin
    stateNext       = stateReg;
    stateNext.sync1 = pinIn;
    stateNext.sync2 = stateReg.sync1;
    stateNext.sync3 = stateReg.sync2;
    for (int i = 0; i < int'(PINS); i++) begin
      stateNext.edgeOut[i] = 1'b0;
      if (stateReg.sync2[i] == stateReg.sync3[i] && stateReg.sync3[i] != stateReg.stable[i]) begin
        stateNext.stable[i]  = stateReg.sync3[i];
        stateNext.edgeOut[i] = edgePolarity[i] ? ~stateReg.sync3[i] : stateReg.sync3[i];
      end
    end
  end

  // Synchronous reset clears every stage.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign edgeSeen = stateReg.edgeOut;

endmodule : ext_edge_detect

// File: verilog/prio_arbiter.sv
// Purpose: Picks the highest priority pending enabled source.
// Assumes: Source 0 has the highest natural order.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module prio_arbiter #(
  parameter int unsigned N = 16
) (
  input  wire logic [N-1:0]   pending,
  input  wire logic [N*3-1:0] priorities,
  output logic                anyValid,
  output logic [3:0]          winIdx,
  output logic [2:0]          winPrio
);

  // Scan from the highest index down so the lowest index wins a tie.
  always_comb begin
    anyValid = 1'b0;
    winIdx   = 4'h0;
    winPrio  = 3'h0;
    for (int i = int'(N) - 1; i >= 0; i--) begin
      if (pending[i] && priorities[i*3 +: 3] != 3'h0 &&
          (!anyValid || priorities[i*3 +: 3] >= winPrio)) begin
        anyValid = 1'b1;
        winIdx   = 4'(i);
        winPrio  = priorities[i*3 +: 3];
      end
    end
  end

endmodule : prio_arbiter

// File: tb/irq_seq_monitor.sv
// Purpose: Port checks for the sequencer.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
module irq_seq_monitor #(
  parameter int unsigned NSRC = irq_seq_pkg::NUM_SOURCES,
  parameter int unsigned NPIN = irq_seq_pkg::NUM_EXT_PINS
) (
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic [NSRC-1:0]   irqEnableRegs,
  input wire logic [NSRC*3-1:0] srcPriority,
  input wire logic              nestingDisable,
  input wire logic              latencyMode,
  input wire logic [2:0]        busMasterPriority,
  input wire logic              prioWrite,
  input wire logic              returnFromIrqOp,
  input wire logic [NSRC-1:0]   irqFlagRegs,
  input wire logic [2:0]        cpuPriorityField,
  input wire logic              priorityUpperBit,
  input wire logic [3:0]        cpuLevel,
  input wire logic              irqPresent,
  input wire logic              wakeUp,
  input wire logic              entryActive,
  input wire logic              returnActive,
  input wire logic [3:0]        entryCycle,
  input wire logic              pushValid,
  input wire logic              vectorFetch,
  input wire logic              isrStart,
  input wire logic              resumeExec,
  input wire logic              fixedLatency,
  input wire logic [3:0]        excTime
);
  logic wakeCause;  // A flagged, enabled source whose priority is not zero.

  // Wake condition; priority zero is disabled.
  always_comb begin
    wakeCause = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (irqFlagRegs[i] && irqEnableRegs[i] && (srcPriority[3*i +: 3] != irq_seq_pkg::PRIO_DISABLED)) begin
        wakeCause = 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Entry: buffer, stack with vector, routine.
  sequence s_entry_push;
    ##2 (pushValid && vectorFetch);
  endsequence
  sequence s_entry_run;
    ##1 (!isrStart) [*7] ##[2:3] isrStart;
  endsequence
  // Return: two pops, fetch, resume.
  sequence s_ret_pop;
    returnActive ##1 returnActive;
  endsequence
  sequence s_ret_resume;
    returnActive ##1 (!returnActive && resumeExec);
  endsequence

  a_entry_push:
    assert property (entryActive && entryCycle == 4'h1 |-> s_entry_push) else $error("entry push late");
  a_entry_length:
    assert property (entryActive && entryCycle == 4'h1 |-> s_entry_run) else $error("entry length wrong");
  a_return_resume:
    assert property ($rose(returnActive) |-> s_ret_pop ##1 s_ret_resume) else $error("return timing wrong");
  a_nest_force:
    assert property (isrStart && nestingDisable |-> cpuPriorityField == irq_seq_pkg::PRIO_NEST_OFF)
      else $error("field not forced");
  a_field_locked:
    assert property (nestingDisable && prioWrite && !irqPresent && !entryActive && !returnActive
      && !returnFromIrqOp |=> $stable(cpuPriorityField)) else $error("locked field changed");
  a_mask_top:
    assert property (cpuPriorityField == 3'h7 |-> !irqPresent) else $error("request above top level");
  a_need_enable:
    assert property ((irqFlagRegs & irqEnableRegs) == '0 |-> !irqPresent) else $error("disabled request shown");
  a_level_join:
    assert property (cpuLevel == {priorityUpperBit, cpuPriorityField}) else $error("level not joined");
  a_wake_follow:
    assert property (1'b1 |=> wakeUp == $past(wakeCause)) else $error("wake signal wrong");
  a_fixed_mode:
    assert property (fixedLatency == (!latencyMode && busMasterPriority == irq_seq_pkg::MASTER_TOP))
      else $error("latency mode wrong");
  a_exc_time:
    assert property (!$past(sys_rst) && fixedLatency == $past(fixedLatency) |->
      excTime == (fixedLatency ? irq_seq_pkg::EXC_FIXED : irq_seq_pkg::EXC_VAR_MIN)) else $error("bad time");
endmodule : irq_seq_monitor

// File: tb/irq_core_model.sv
// Purpose: Behavioural processor core facing the sequencer.
// Assumes: Push stacks, resume unstacks.
// Notes:   Empty stack shows inverted pop lines.
`timescale 1ns/1ps
module irq_core_model (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        stall,
  input  wire logic        retReq,
  input  wire logic        sleepReq,
  input  wire logic        pushValid,
  input  wire logic [23:0] pushPc,
  input  wire logic [7:0]  pushStatusLow,
  input  wire logic        pushUpperBit,
  input  wire logic        pushFrameActive,
  input  wire logic        resumeExec,
  input  wire logic [2:0]  cpuPriorityField,
  output logic             instrDone,
  output logic             returnFromIrqOp,
  output logic             powerSaveOp,
  output logic [23:0]      currentPc,
  output logic [7:0]       statusLowByte,
  output logic             stackFrameActive,
  output logic [23:0]      popPc,
  output logic [7:0]       popStatusLow,
  output logic             popUpperBit,
  output logic             popFrameActive
);
  logic [33:0] frames [$];  // Saved contexts, newest at the back.
  logic [33:0] top = '0;    // Frame offered for unstacking.

  // Stall holds the boundary low.
  assign instrDone = !stall;
  // Field in the top status bits.
  assign statusLowByte = {cpuPriorityField, currentPc[4:0]};
  assign {popPc, popStatusLow, popUpperBit, popFrameActive} = top;

  initial begin
    returnFromIrqOp = 1'b0;
    powerSaveOp = 1'b0;
    currentPc = 24'h000100;
    stackFrameActive = 1'b0;
  end

  // Strobes and stack move on the rising edge.
  always @(posedge clock) begin
    returnFromIrqOp <= retReq;
    powerSaveOp <= sleepReq;
    if (sys_rst) begin
      frames.delete();
    end else begin
      if (instrDone) currentPc <= currentPc + 24'h2;
      // Entry stacks the context.
      if (pushValid) frames.push_back({pushPc, pushStatusLow, pushUpperBit, pushFrameActive});
      // Resume drops the restored frame.
      if (resumeExec && frames.size() != 0) frames.pop_back();
    end
  end

  // Pop lines settle half a cycle later.
  always @(negedge clock) begin
    top <= (frames.size() != 0) ? frames[$] : ~top;
    stackFrameActive <= (frames.size() != 0);
  end
endmodule : irq_core_model

// File: tb/tb_interrupt_entry_return_sequencer.sv
// Purpose: Self-checking bench for the sequencer.
// Assumes: Inputs change on the falling edge.
// Notes:   The bench works out winners itself.
`timescale 1ns/1ps
module tb_interrupt_entry_return_sequencer;
  logic        clock = 1'b0, sys_rst = 1'b1;
  logic [15:0] srcRequest = '0, flagClear = '0, irqEnableRegs = '0, req;
  logic [47:0] srcPriority = '0;
  logic [4:0]  extPin = '0, extEdgePolarity = '0;
  logic        nestingDisable = 1'b0, latencyMode = 1'b0, prioWrite = 1'b0;
  logic [2:0]  busMasterPriority = '0, prioWriteData = '0;
  logic        doubleMoveVis = 1'b0, visStall = 1'b0, visRepeatLast = 1'b0;
  logic        stall = 1'b1, retReq = 1'b0, sleepReq = 1'b0, pol, conv;
  logic        instrDone, returnFromIrqOp, powerSaveOp, stackFrameActive, popUpperBit, popFrameActive;
  logic [23:0] currentPc, popPc, pushPc, restorePc, savedPc;
  logic [7:0]  statusLowByte, popStatusLow, pushStatusLow, restoreStatusLow;
  logic [15:0] irqFlagRegs;
  logic [2:0]  cpuPriorityField;
  logic [3:0]  cpuLevel, entryCycle, vectorIdx, excTime;
  logic        priorityUpperBit, irqPresent, wakeUp, sleeping, entryActive, returnActive, pushValid;
  logic        pushUpperBit, pushFrameActive, vectorFetch, isrStart, resumeExec, restoreFrameActive;
  logic        convRequest, fixedLatency;
  int          err_count = 0, compares = 0, fld, win;

  interrupt_entry_return_sequencer dut_u (.*);
  irq_core_model core_u (.*);

  initial forever #4 clock = ~clock;

  // Prints counts and verdict, then ends.
  task automatic test_done();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // Four-state compare keeps unknowns from passing.
  task automatic check(input logic [31:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  // Winner above the field; strict compare keeps lowest index.
  function automatic int pick(input logic [15:0] f, e, input logic [47:0] p, input int lvl);
    int best, idx;
    best = lvl;
    idx = -1;
    for (int i = 0; i < 16; i++) begin
      if (f[i] && e[i] && int'(p[3*i +: 3]) > best) begin
        best = int'(p[3*i +: 3]);
        idx = i;
      end
    end
    return idx;
  endfunction : pick

  function automatic logic sig(input int k);
    return (k == 0) ? vectorFetch : (k == 1) ? isrStart : resumeExec;
  endfunction : sig

  // Waits for a pulse under a bound; running out ends the run.
  task automatic wait_hi(input int k);
    for (int n = 0; sig(k) !== 1'b1; n++) begin
      @(negedge clock);
      if (n > 40) begin
        err_count++;
        $display("mismatch at %0t: wait %0d ran out", $time, k);
        test_done();
      end
    end
  endtask : wait_hi

  task automatic pulse_clear();
    flagClear = 16'hffff;
    @(negedge clock);
    flagClear = '0;
  endtask : pulse_clear

  task automatic set_field(input logic [2:0] v);
    prioWrite = 1'b1;
    prioWriteData = v;
    @(negedge clock);
    prioWrite = 1'b0;
    @(negedge clock);
  endtask : set_field

  // One entry and return for winner w, prior field f.
  task automatic service(input int w, input int f);
    wait_hi(0);
    check(vectorIdx, w, "vector");
    check(pushStatusLow[7:5], f, "stacked field");
    savedPc = pushPc;
    pulse_clear();
    wait_hi(1);
    check(cpuPriorityField, nestingDisable ? 32'h7 : 32'(srcPriority[3*w +: 3]), "isr field");
    retReq = 1'b1;
    @(negedge clock);
    retReq = 1'b0;
    wait_hi(2);
    check(cpuPriorityField, f, "field after return");
    check(restorePc, savedPc, "restored pc");
  endtask : service

  initial begin
    void'($urandom(32'h473a));
    repeat (8) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    check(irqFlagRegs, 0, "flags after reset");
    check(cpuLevel, 0, "level after reset");
    for (int k = 0; k < 4; k++) begin
      latencyMode = k[0];
      busMasterPriority = k[1] ? 3'h3 : 3'h0;
      repeat (2) @(negedge clock);
      check(excTime, (k == 0) ? 13 : 9, "exception time");
    end
    latencyMode = 1'b0;
    busMasterPriority = 3'h0;
    // Random setups, one entry and return each when a source beats the field.
    for (int it = 0; it < 16; it++) begin
      nestingDisable = 1'b0;
      fld = $urandom % 4;
      set_field(3'(fld));
      nestingDisable = 1'(it % 2);
      if (nestingDisable) begin
        set_field(3'(fld + 1));
        check(cpuPriorityField, fld, "locked field");
      end
      for (int i = 0; i < 16; i++) srcPriority[3*i +: 3] = 3'($urandom % 5);
      irqEnableRegs = 16'($urandom);
      req = 16'($urandom);
      srcRequest = req;
      {doubleMoveVis, visStall, visRepeatLast} = 3'($urandom);
      @(negedge clock);
      srcRequest = '0;
      @(negedge clock);
      check(irqFlagRegs, req, "flags sampled");
      win = pick(req, irqEnableRegs, srcPriority, fld);
      check(irqPresent, win >= 0, "presented");
      stall = 1'b0;
      if (win >= 0) service(win, fld);
      else pulse_clear();
      stall = 1'b1;
      @(negedge clock);
    end
    // Each pin: only the selected edge sets its flag.
    irqEnableRegs = '0;
    for (int i = 0; i < 5; i++) begin
      pol = 1'($urandom);
      extEdgePolarity[i] = pol;
      extPin[i] = !pol;
      repeat (6) @(negedge clock);
      pulse_clear();
      extPin[i] = pol;
      repeat (6) @(negedge clock);
      check(irqFlagRegs[i], 0, "inactive edge");
      extPin[i] = !pol;
      conv = 1'b0;
      repeat (8) begin
        @(negedge clock);
        conv |= convRequest;
      end
      check(irqFlagRegs[i], 1, "active edge");
      check(conv, i == 0, "conversion request");
    end
    // Sleep: priority 0 cannot wake; 2 resumes, 5 vectors.
    pulse_clear();
    stall = 1'b0;
    nestingDisable = 1'b0;
    set_field(3'h3);
    srcPriority = '0;
    srcPriority[5:3] = 3'h2;
    srcPriority[8:6] = 3'h5;
    irqEnableRegs = 16'h0007;
    for (int k = 1; k < 3; k++) begin
      sleepReq = 1'b1;
      @(negedge clock);
      sleepReq = 1'b0;
      srcRequest = 16'h0001;
      @(negedge clock);
      srcRequest = '0;
      repeat (4) @(negedge clock);
      check(sleeping, 1, "zero priority no wake");
      srcRequest = 16'(1 << k);
      @(negedge clock);
      srcRequest = '0;
      if (k == 1) begin
        wait_hi(2);
        check(cpuPriorityField, 3, "resume without vector");
        pulse_clear();
      end else service(2, 3);
    end
    test_done();
  end
endmodule : tb_interrupt_entry_return_sequencer

bind interrupt_entry_return_sequencer irq_seq_monitor #(.NSRC(NSRC), .NPIN(NPIN)) mon_u (.*);
